//--- design/mdc_pkg.sv
// constants shared by both ends of the multichannel synthesis link
// assumes a single 10 MHz system clock on both ends
package mdc_pkg;
   // channel layout
   localparam int N_CH    = 4;
   localparam int PRI     = 1;               // primary channel index
   localparam int ACC_W   = 32;
   localparam int PHASE_W = 14;
   localparam int DAC_W   = 10;
   localparam int SAMP_W  = 11;              // signed cosine sample
   localparam int SUM_W   = 13;              // summing node width

   // device register offsets on the link
   localparam logic [4:0] ADDR_CHAN_SEL  = 5'h00;
   localparam logic [4:0] ADDR_FUNC      = 5'h01;
   localparam logic [4:0] ADDR_CHAN_FUNC = 5'h03;
   localparam logic [4:0] ADDR_FREQ      = 5'h04;
   localparam logic [4:0] ADDR_PHASE     = 5'h05;
   localparam logic [4:0] ADDR_AMP       = 5'h06;

   // field positions
   localparam int CSR_EN_LSB      = 4;       // enable bit of channel n
   localparam int FUNC_TONE_BIT   = 2;       // test-tone mode
   localparam int FUNC_SYNC_OFF   = 5;       // sync clock disable
   localparam int CFR_MATCH_BIT   = 0;       // matched pipeline delay
   localparam int CFR_PWRDN_BIT   = 7;       // digital power-down
   localparam int CFR_COARSE_LSB  = 16;      // coarse level, 3 bits
   localparam int AMP_EN_BIT      = 12;      // fine multiplier enable
   localparam logic [3:0] COARSE_BASE = 4'ha; // shift at coarse zero

   // reset values
   localparam logic [7:0]  CSR_RST  = 8'h00;
   localparam logic [31:0] FREQ_RST = 32'h0000_0000;
   localparam logic [13:0] PHASE_RST = 14'h0000;

   // sync clock: four system clocks, sampled in its first high cycle
   localparam logic [1:0] SYNC_SAMPLE = 2'h2;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int UPD_MIN_NS    = 400;      // one sync clock period
   localparam int UPD_HOLD =
      (UPD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // host command registers
   localparam logic [3:0] H_LINK_ADDR = 4'h0;
   localparam logic [3:0] H_LINK_DATA = 4'h1;
   localparam logic [3:0] H_CTRL      = 4'h2;
   localparam logic [3:0] H_STATUS    = 4'h3;
   localparam int H_CTRL_UPD_BIT  = 0;
   localparam int H_CTRL_RST_BIT  = 1;
   localparam int H_CTRL_PROF_LSB = 4;
endpackage

//--- design/mdc_link_if.sv
// link between the synthesis device and its host controller
// assumes both ends run on the same system clock
interface mdc_link_if;
   logic        wrStb;        // one-cycle register write
   logic [4:0]  wrAddr;
   logic [31:0] wrData;
   logic        ioUpdate;     // buffered-to-active transfer strobe
   logic [3:0]  profile;      // profile inputs
   logic        masterReset;  // level, clears the device
   logic        syncClk;      // quarter-rate sync clock

   modport device (
      input  wrStb, wrAddr, wrData, ioUpdate, profile, masterReset,
      output syncClk
   );
   modport host (
      output wrStb, wrAddr, wrData, ioUpdate, profile, masterReset,
      input  syncClk
   );
endinterface

//--- design/mdc_device.sv
// four-channel synthesis core with summing node and converter code
// assumes the host drives the link from logic on the same mclk

// How it works
// - 32-bit accumulator adds tuning word each clock
// - cosine converts offset phase to amplitude
// - 14-bit phase offset added before conversion
// - primary and powered-up aux summed into converter code, except aux zero in test tone
// - aux channels at least 18 dB below full scale
// - channel enables act on write, no update
// - host powers down aux for single tone
// - master reset clears mode, tuning, phase
// - tuning and phase writes wait for update
// - matched delay aligns changes in single tone
// - shared writes reach every enabled channel
// - each channel independently programmed, profile-updated
// - coarse level minus sixty plus six dB
// - host sets coarse level for multitone
// - fine multiplier applied when its enable set
// - spur cancel sums attenuated aux outputs
// - test tone modulates primary by aux zero
// - update rising edge copies buffers to active
// - quarter-rate sync clock samples update, profile
module mdc_device (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // link to the host
   mdc_link_if.device       link,
   // converter input code, offset binary
   output      logic [9:0]  dacCode
);

   typedef struct packed {
      logic [7:0]              channel_select;
      logic [23:0]             funcB;
      logic [23:0]             funcA;
      logic [3:0][23:0]        cfrB;
      logic [3:0][23:0]        cfrA;
      logic [3:0][31:0]        ftwB;
      logic [3:0][31:0]        ftwA;
      logic [3:0][13:0]        powB;
      logic [3:0][13:0]        powA;
      logic [3:0][23:0]        ampB;
      logic [3:0][23:0]        ampA;
      logic [3:0][31:0]        acc;
      logic [3:0][13:0]        ph;
      logic [3:0][10:0]        cosv;
      logic [3:0][10:0]        lvl;
      logic [13:0]             powDly;
      logic [2:0][12:0]        ampDly;
      logic [1:0]              syncCnt;
      logic                    syncClk;
      logic                    updPrev;
      logic [3:0]              profPrev;
      logic [9:0]              dac;
   } mdc_dev_state_t;

   mdc_dev_state_t state_reg;
   mdc_dev_state_t state_next;

   // parabolic cosine: sine of phase plus a quarter turn
   function automatic logic [10:0] cosine(input logic [13:0] p);
      logic [13:0] q;
      logic [25:0] h;
      logic [25:0] prod;
      logic [10:0] mag;
      q = p + 14'h1000;
      h = {13'h0000, q[12:0]};
      prod = 26'(h * (26'h000_2000 - h));
      mag = {1'b0, prod[24:15]};
      cosine = q[13] ? 11'(-mag) : mag;
   endfunction

   // signed sample times a 10-bit fraction of full scale
   function automatic logic [10:0] scale(input logic [10:0] s,
                                         input logic [9:0]  m);
      logic signed [21:0] prod;
      prod = $signed(s) * $signed({1'b0, m});
      scale = 11'(prod >>> 10);
   endfunction

   logic               sample;
   logic               updEvent;
   logic               matched;
   logic [13:0]        pw;
   logic [12:0]        am;
   logic [3:0]         shamt;
   logic signed [12:0] sum;
   logic signed [21:0] modProd;

   always_comb begin
      state_next = state_reg;
      sample   = 1'b0;
      updEvent = 1'b0;
      matched  = 1'b0;
      pw       = 14'h0000;
      am       = 13'h0000;
      shamt    = 4'h0;
      sum      = 13'sh0000;
      modProd  = 22'sh000000;

      // writes: select register now, the rest into the buffers
      if (link.wrStb) begin
         case (link.wrAddr)
            mdc_pkg::ADDR_CHAN_SEL:
               state_next.channel_select = link.wrData[7:0];
            mdc_pkg::ADDR_FUNC:
               state_next.funcB = link.wrData[23:0];
            default: begin
               for (int n = 0; n < mdc_pkg::N_CH; n++) begin
                  if (state_reg.channel_select[mdc_pkg::CSR_EN_LSB + n]) begin
                     case (link.wrAddr)
                        mdc_pkg::ADDR_CHAN_FUNC:
                           state_next.cfrB[n] = link.wrData[23:0];
                        mdc_pkg::ADDR_FREQ:
                           state_next.ftwB[n] = link.wrData;
                        mdc_pkg::ADDR_PHASE:
                           state_next.powB[n] = link.wrData[13:0];
                        mdc_pkg::ADDR_AMP:
                           state_next.ampB[n] = link.wrData[23:0];
                        default: ;
                     endcase
                  end
               end
            end
         endcase
      end

      // sync clock runs on regardless; only the pin is gated
      state_next.syncCnt = state_reg.syncCnt + 2'h1;
      state_next.syncClk = state_next.syncCnt[1] &
                           ~state_reg.funcA[mdc_pkg::FUNC_SYNC_OFF];

      // strobe and profiles are looked at once per sync period
      sample = (state_reg.syncCnt == mdc_pkg::SYNC_SAMPLE);
      if (sample) begin
         state_next.updPrev  = link.ioUpdate;
         state_next.profPrev = link.profile;
         updEvent = (link.ioUpdate & ~state_reg.updPrev) |
                    (link.profile != state_reg.profPrev);
      end
      if (updEvent) begin
         state_next.funcA = state_reg.funcB;
         state_next.cfrA  = state_reg.cfrB;
         state_next.ftwA  = state_reg.ftwB;
         state_next.powA  = state_reg.powB;
         state_next.ampA  = state_reg.ampB;
      end

      // matched delay only when aux channels are down, no test tone
      matched = state_reg.cfrA[mdc_pkg::PRI][mdc_pkg::CFR_MATCH_BIT] &
                ~state_reg.funcA[mdc_pkg::FUNC_TONE_BIT] &
                state_reg.cfrA[0][mdc_pkg::CFR_PWRDN_BIT] &
                state_reg.cfrA[2][mdc_pkg::CFR_PWRDN_BIT] &
                state_reg.cfrA[3][mdc_pkg::CFR_PWRDN_BIT];
      // phase enters one stage, amplitude three stages after tuning
      state_next.powDly = state_reg.powA[mdc_pkg::PRI];
      state_next.ampDly = {state_reg.ampDly[1:0],
                           state_reg.ampA[mdc_pkg::PRI][12:0]};

      // per-channel pipeline: accumulate, offset, cosine, fine scale
      for (int n = 0; n < mdc_pkg::N_CH; n++) begin
         pw = (n == mdc_pkg::PRI && matched) ? state_reg.powDly
                                             : state_reg.powA[n];
         am = (n == mdc_pkg::PRI && matched) ? state_reg.ampDly[2]
                                             : state_reg.ampA[n][12:0];
         state_next.acc[n]  = state_reg.acc[n] + state_reg.ftwA[n];
         state_next.ph[n]   = state_reg.acc[n][31:18] + pw;
         state_next.cosv[n] = cosine(state_reg.ph[n]);
         state_next.lvl[n]  = am[mdc_pkg::AMP_EN_BIT]
                              ? scale(state_reg.cosv[n], am[9:0])
                              : state_reg.cosv[n];
      end

      // summing node: primary plus coarse-shifted aux channels
      sum = 13'($signed(state_reg.lvl[mdc_pkg::PRI]));
      if (state_reg.funcA[mdc_pkg::FUNC_TONE_BIT]) begin
         // aux zero scales the primary instead of adding a tone
         modProd = $signed(state_reg.lvl[mdc_pkg::PRI]) *
                   $signed(state_reg.lvl[0]);
         sum = sum + 13'(modProd >>> 9);
      end
      for (int n = 0; n < mdc_pkg::N_CH; n++) begin
         shamt = mdc_pkg::COARSE_BASE -
                 {1'b0, state_reg.cfrA[n][mdc_pkg::CFR_COARSE_LSB +: 3]};
         if (n != mdc_pkg::PRI &&
             !state_reg.cfrA[n][mdc_pkg::CFR_PWRDN_BIT] &&
             !(n == 0 && state_reg.funcA[mdc_pkg::FUNC_TONE_BIT])) begin
            // shift of at least three keeps aux 18 dB down or more
            sum = sum + 13'($signed(state_reg.lvl[n]) >>> shamt);
         end
      end

      // 13 bits hold +-512 plus three aux and full modulation, so
      // the sum never wraps; it is clipped to the converter range
      if (sum > 13'sd511)
         state_next.dac = 10'h3ff;
      else if (sum < -13'sd512)
         state_next.dac = 10'h000;
      else
         state_next.dac = {~sum[9], sum[8:0]};

      // master reset from the host empties everything
      if (link.masterReset)
         state_next = '0;
   end

   // single state register
   always_ff @(posedge mclk) begin
      if (rst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign dacCode      = state_reg.dac;
   assign link.syncClk = state_reg.syncClk;

endmodule

//--- design/mdc_host.sv
// host controller: software command port to the synthesis link
// assumes software uses a one-cycle strobe port on the same mclk
module mdc_host (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // software register port
   input  wire logic [3:0]   regAddr,
   input  wire logic [31:0]  regWrData,
   input  wire logic         regWrStb,
   input  wire logic         regRdStb,
   output      logic [31:0]  regRdData,
   // link to the device
   mdc_link_if.host          link
);

   typedef struct packed {
      logic [4:0]  linkAddr;
      logic        wrStb;
      logic [4:0]  wrAddr;
      logic [31:0] wrData;
      logic [2:0]  updCnt;
      logic        ioUpdate;
      logic        mReset;
      logic [3:0]  profile;
      logic [31:0] rdData;
   } mdc_host_state_t;

   mdc_host_state_t state_reg;
   mdc_host_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.wrStb = 1'b0;

      // update strobe held one whole sync period, so the device
      // sees exactly one sample of it whatever the phase
      if (state_reg.updCnt != 3'h0)
         state_next.updCnt = state_reg.updCnt - 3'h1;
      state_next.ioUpdate = (state_next.updCnt != 3'h0);

      if (regWrStb) begin
         case (regAddr)
            mdc_pkg::H_LINK_ADDR:
               state_next.linkAddr = regWrData[4:0];
            mdc_pkg::H_LINK_DATA: begin
               // software selects channels first via address zero
               state_next.wrStb  = 1'b1;
               state_next.wrAddr = state_reg.linkAddr;
               state_next.wrData = regWrData;
            end
            mdc_pkg::H_CTRL: begin
               state_next.mReset  = regWrData[mdc_pkg::H_CTRL_RST_BIT];
               state_next.profile =
                  regWrData[mdc_pkg::H_CTRL_PROF_LSB +: 4];
               if (regWrData[mdc_pkg::H_CTRL_UPD_BIT]) begin
                  state_next.updCnt   = 3'(mdc_pkg::UPD_HOLD);
                  state_next.ioUpdate = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // read data stand one cycle after the strobe, zero otherwise
      state_next.rdData = 32'h0000_0000;
      if (regRdStb) begin
         case (regAddr)
            mdc_pkg::H_LINK_ADDR:
               state_next.rdData = {27'h0000000, state_reg.linkAddr};
            mdc_pkg::H_LINK_DATA:
               state_next.rdData = state_reg.wrData;
            mdc_pkg::H_CTRL:
               state_next.rdData = {24'h000000, state_reg.profile,
                                    2'h0, state_reg.mReset, 1'b0};
            mdc_pkg::H_STATUS:
               state_next.rdData = {30'h00000000, link.syncClk,
                                    state_reg.ioUpdate};
            default: ;
         endcase
      end
   end

   // single state register
   always_ff @(posedge mclk) begin
      if (rst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign regRdData        = state_reg.rdData;
   assign link.wrStb       = state_reg.wrStb;
   assign link.wrAddr      = state_reg.wrAddr;
   assign link.wrData      = state_reg.wrData;
   assign link.ioUpdate    = state_reg.ioUpdate;
   assign link.profile     = state_reg.profile;
   assign link.masterReset = state_reg.mReset;

endmodule

//--- test/mdc_link_properties.sv
// link checker: sync divider, update pulse, resets and converter code
// assumes it sits beside the link interface on the shared mclk
module mdc_link_properties (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // link signals
   input wire logic       wrStb,
   input wire logic [4:0] wrAddr,
   input wire logic       ioUpdate,
   input wire logic [3:0] profile,
   input wire logic       masterReset,
   input wire logic       syncClk,
   // converter code
   input wire logic [9:0] dacCode
);
   logic       zeroed;   // no update seen since the last clear
   logic [3:0] age;      // cycles since the last clear, saturating
   logic [1:0] phase;    // mirror of the sync divider

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // both resets restart the divider, so the mirror restarts too
   always_ff @(posedge mclk) begin
      if (rst || masterReset) begin
         zeroed <= 1'b1;
         age    <= 4'h0;
         phase  <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
         // conservative: any update request ends the idle claim
         if (ioUpdate || profile != 4'h0) begin
            zeroed <= 1'b0;
         end
         if (age != 4'hf) begin
            age <= age + 4'h1;
         end
      end
   end

   property p_sync_phase;
      disable iff (rst || masterReset) syncClk == phase[1];
   endproperty
   a_sync_phase: assert property (p_sync_phase)
      else $error("sync clock off its quarter-rate phase");

   property p_sync_hi;
      disable iff (rst || masterReset)
      $rose(syncClk) |=> syncClk ##1 !syncClk;
   endproperty
   a_sync_hi: assert property (p_sync_hi)
      else $error("sync clock high phase not two cycles");

   property p_sync_lo;
      disable iff (rst || masterReset)
      $fell(syncClk) |=> !syncClk ##1 syncClk;
   endproperty
   a_sync_lo: assert property (p_sync_lo)
      else $error("sync clock low phase not two cycles");

   property p_upd_len;
      $rose(ioUpdate) |-> ioUpdate [*4] ##1 !ioUpdate;
   endproperty
   a_upd_len: assert property (p_upd_len)
      else $error("update strobe not one sync period long");

   property p_mrst_clr;
      masterReset |=> dacCode == 10'h000;
   endproperty
   a_mrst_clr: assert property (p_mrst_clr)
      else $error("converter code not cleared by master reset");

   property p_mrst_rel;
      $fell(masterReset) |-> ##[1:10] dacCode == 10'h3ff;
   endproperty
   a_mrst_rel: assert property (p_mrst_rel)
      else $error("zero tuning not full scale after master reset");

   property p_idle_full;
      zeroed && age > 4'h9 |-> dacCode == 10'h3ff;
   endproperty
   a_idle_full: assert property (p_idle_full)
      else $error("buffered write reached output without update");

   // the copy plus four pipeline stages keep the old code this long
   property p_upd_lat;
      zeroed && age > 4'h9 && $rose(ioUpdate)
         |-> (dacCode == 10'h3ff) [*5];
   endproperty
   a_upd_lat: assert property (p_upd_lat)
      else $error("update reached output ahead of the pipeline");

   c_update: cover property ($rose(ioUpdate));
   c_mrst:   cover property ($fell(masterReset));
   c_freq:   cover property (wrStb && wrAddr == mdc_pkg::ADDR_FREQ);
   c_prof:   cover property ($changed(profile));
endmodule

//--- test/multichannel_dds_core_bench.sv
// bench: host and device joined by the link, driven from the sw port
// assumes package, link interface and both ends compiled before it
module multichannel_dds_core_bench;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [4:0]  a;    // link offset written
      logic [31:0] d;    // link data written
      logic [4:0]  ea;   // offset expected on the wire
      logic [31:0] ed;   // data expected on the wire
   } mdc_row_t;

   logic        mclk;
   logic        rst;
   logic [3:0]  regAddr;
   logic [31:0] regWrData;
   logic        regWrStb;
   logic        regRdStb;
   logic [31:0] regRdData;
   logic [9:0]  dacCode;
   logic [31:0] rd;
   int          errors;
   int          nChecks;
   int          cycles;
   mdc_row_t    rows [6];

   mdc_link_if lnk ();
   mdc_host i_mdc_host (.mclk(mclk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .link(lnk));
   mdc_device i_mdc_device (.mclk(mclk), .rst(rst), .link(lnk),
      .dacCode(dacCode));
   mdc_link_properties i_props (.mclk(mclk), .rst(rst),
      .wrStb(lnk.wrStb), .wrAddr(lnk.wrAddr), .ioUpdate(lnk.ioUpdate),
      .profile(lnk.profile), .masterReset(lnk.masterReset),
      .syncClk(lnk.syncClk), .dacCode(dacCode));

   // 10 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic end_sim;
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_dac(input logic [9:0] exp);
      nChecks++;
      if (dacCode !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, dacCode,
            exp);
      end
   endtask

   // bounded poll of the converter code, then compare
   task automatic wait_dac(input logic [9:0] exp);
      for (int i = 0; i < 40 && dacCode !== exp; i++) begin
         @(posedge mclk);
         #1;
      end
      chk_dac(exp);
   endtask

   task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge mclk);
      regWrStb  <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge mclk);
      regRdStb <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic link_wr(input logic [4:0] a, input logic [31:0] d);
      sw_wr(mdc_pkg::H_LINK_ADDR, {27'h0, a});
      sw_wr(mdc_pkg::H_LINK_DATA, d);
   endtask

   task automatic update;
      sw_wr(mdc_pkg::H_CTRL, 32'h1);
   endtask

   initial begin
      rst       = 1'b1;
      regAddr   = 4'h0;
      regWrData = 32'h0;
      regWrStb  = 1'b0;
      regRdStb  = 1'b0;
      // select is zero, so offsets 3..6 reach no channel; select last
      rows[0] = '{5'h01, 32'h0000_0000, 5'h01, 32'h0000_0000};
      rows[1] = '{5'h03, 32'h0007_0081, 5'h03, 32'h0007_0081};
      rows[2] = '{5'h04, 32'h1234_5678, 5'h04, 32'h1234_5678};
      rows[3] = '{5'h05, 32'h0000_1fff, 5'h05, 32'h0000_1fff};
      rows[4] = '{5'h06, 32'h0000_13ff, 5'h06, 32'h0000_13ff};
      rows[5] = '{5'h00, 32'h0000_0020, 5'h00, 32'h0000_0020};
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      wait_dac(10'h3ff);
      foreach (rows[i]) begin
         link_wr(rows[i].a, rows[i].d);
         #1;
         chk_word({26'h0, lnk.wrStb, lnk.wrAddr}, {27'h1, rows[i].ea});
         chk_word(lnk.wrData, rows[i].ed);
      end
      // primary to 180 degrees, held in the buffer until update
      link_wr(mdc_pkg::ADDR_PHASE, 32'h0000_2000);
      repeat (12) @(posedge mclk);
      #1 chk_dac(10'h3ff);
      link_wr(mdc_pkg::ADDR_CHAN_SEL, 32'h10);
      link_wr(mdc_pkg::ADDR_CHAN_FUNC, 32'h0007_0000);
      update();
      sw_rd(mdc_pkg::H_STATUS, rd);
      chk_word({31'h0, rd[0]}, 32'h1);
      // -512 from the primary plus +64 from aux zero at top coarse
      wait_dac(10'h040);
      // test tone: aux zero scales the primary instead of adding
      link_wr(mdc_pkg::ADDR_FUNC, 32'h4);
      update();
      wait_dac(10'h000);
      // only aux zero is selected, so the primary keeps still; test tone
      // is still on, so aux zero swings it between double and cancelled
      link_wr(mdc_pkg::ADDR_FREQ, 32'h8000_0000);
      update();
      wait_dac(10'h200);
      @(posedge mclk);
      #1 chk_dac(10'h000);
      // master reset clears tuning, phase and modes
      sw_wr(mdc_pkg::H_CTRL, 32'h2);
      repeat (3) @(posedge mclk);
      #1 chk_dac(10'h000);
      sw_wr(mdc_pkg::H_CTRL, 32'h0);
      wait_dac(10'h3ff);
      // half-scale word flips the primary by 180 degrees each clock
      link_wr(mdc_pkg::ADDR_CHAN_SEL, 32'h20);
      link_wr(mdc_pkg::ADDR_FREQ, 32'h8000_0000);
      update();
      wait_dac(10'h000);
      for (int i = 1; i < 5; i++) begin
         @(posedge mclk);
         #1 chk_dac(i[0] ? 10'h3ff : 10'h000);
      end
      // second master reset, then fine scale halves the primary and
      // three aux at top coarse add 64 each; a profile change loads it
      sw_wr(mdc_pkg::H_CTRL, 32'h2);
      sw_wr(mdc_pkg::H_CTRL, 32'h0);
      link_wr(mdc_pkg::ADDR_CHAN_SEL, 32'h20);
      link_wr(mdc_pkg::ADDR_AMP, 32'h0000_1200);
      link_wr(mdc_pkg::ADDR_CHAN_SEL, 32'hd0);
      link_wr(mdc_pkg::ADDR_CHAN_FUNC, 32'h0007_0000);
      sw_wr(mdc_pkg::H_CTRL, 32'h10);
      wait_dac(10'h3c0);
      // single tone: aux powered down and deselected, primary alone
      link_wr(mdc_pkg::ADDR_CHAN_FUNC, 32'h0007_0080);
      link_wr(mdc_pkg::ADDR_CHAN_SEL, 32'h20);
      update();
      wait_dac(10'h300);
      // unmapped software address reads as zero
      sw_rd(4'h9, rd);
      chk_word(rd, 32'h0);
      // read data stand one cycle only, then drop to zero
      sw_rd(mdc_pkg::H_LINK_DATA, rd);
      chk_word(rd, 32'h0000_0020);
      @(posedge mclk);
      #1 chk_word(regRdData, 32'h0);
      end_sim();
   end
endmodule
